// ==== pmsii_status_image.sv ====
// Port status input bit image read cyclically by the fieldbus master
// Function
// [R1] The image is read-only and any write attempt from the master is ignored.
// [R2] A minor error sets the warning bit 07 while link-ready stays on.
// [R3] The warning bit clears by itself once the minor error condition is gone.
// [R4] A moderate or fatal error drops link-ready and sets error bit 0A, held until power is cycled.
// [R5] Link-ready bit 0B is on only while the link is up and requests can be served.
// [R6] Link-ready is off whenever requests cannot be served correctly.
// [R7] Port n reports signal line at bit 2(n-1) and aux input at bit 2(n-1)+1, high reads 1.
// [R8] Signal bits are valid only in standard-I/O input mode, aux bits once the mode is set.
// [R9] Even short bits follow each port's signal line short, odd bits stay unused.
// [R10] A supply rail short bit is latched until power is cycled.
// [R11] Bit 38 shows supply at or below 18 V and bit 39 at or below 11 V.
// [R12] An event bit sets on a device event and clears on a clear request or a read.
// [R13] Mode-running, data-valid and validation-error flags sit in words 40, 50, 60.
// [R14] The whole image is refreshed on every cyclic exchange.
`timescale 1ns/1ps
`default_nettype none
`include "pmsii_params.svh"
module pmsii_status_image (
    input  wire logic               clock_i,              // Device clock, 10 MHz
    input  wire logic               rst_b_i,              // Power-up reset, active low
    input  wire logic [7:0]         line_level_i,         // Signal line levels, pins
    input  wire logic [7:0]         port_aux_input_i,     // Aux input levels, pins
    input  wire logic [7:0]         line_short_i,         // Signal line short, pins
    input  wire logic [7:0]         supply_short_i,       // Supply short trip, pins
    input  wire logic               volt_le18_i,          // Supply at or below 18 V
    input  wire logic               volt_le11_i,          // Supply at or below 11 V
    input  wire logic               minor_error_i,        // Minor error present
    input  wire logic               fatal_error_i,        // Moderate or fatal error
    input  wire logic               link_established_i,   // Data link up
    input  wire logic               can_serve_i,          // Requests can be served
    input  wire logic [7:0]         mode_configured_i,    // Port mode set
    input  wire logic [7:0]         standard_io_mode_i,   // Port in standard-I/O input
    input  wire logic [7:0]         link_mode_running_i,  // Sensor link mode running
    input  wire logic [7:0]         pd_valid_i,           // Process data valid
    input  wire logic [7:0]         valid_error_i,        // Validation error
    input  wire logic [7:0]         evt_report_i,         // Event reported, pulse
    input  wire logic [7:0]         evt_clear_req_i,      // Clear from output_bit_image
    input  wire logic [7:0]         evt_read_i,           // Event was read, pulse
    input  wire logic               cyc_refresh_i,        // Cyclic exchange strobe
    input  wire logic               rd_en_i,              // Read strobe
    input  wire logic [6:0]         rd_addr_i,            // Bit address of word
    output var  pmsii_pkg::pmsii_word_t rd_data_o,        // Read word
    output logic                    rd_valid_o,           // Read answer strobe
    input  wire logic               wr_en_i,              // Write attempt
    input  wire logic [6:0]         wr_addr_i,            // Write bit address
    input  wire logic [15:0]        wr_data_i,            // Write data, discarded
    output logic                    wr_ignored_o          // Write refused strobe
);
    import pmsii_pkg::*;

    pmsii_main_t   st_r;
    pmsii_main_t   st_nxt;
    pmsii_latch_if lif ();
    logic          ready_now;
    pmsii_pins_t   s;

    // Word lookup; only 16-bit aligned addresses inside the map return image data, others read zero
    function automatic pmsii_word_t read_word(input pmsii_image_t img,
                                              input logic [6:0] addr);
        pmsii_word_t w;
        w = `PMSII_RST_WORD;
        if (addr[3:0] == 4'h0 && addr[6:4] < 3'(`PMSII_NWORDS))
        begin
            w = img[addr[6:4]];
        end
        return w;
    endfunction

    pmsii_latch_unit pmsii_latch_unit_i (
        .clock_i (clock_i),
        .rst_b_i (rst_b_i),
        .lif     (lif)
    );

    assign s = st_r.sync2;
    assign lif.fatal        = fatal_error_i;                      // [R4]
    assign lif.supply_short = s.supply_short;                     // [R10]
    assign lif.evt_report   = evt_report_i;                       // [R12]
    assign lif.evt_clear    = evt_clear_req_i;                    // [R12]
    assign lif.evt_read     = evt_read_i;                         // [R12]

    // Fatal input also gates directly so ready drops in the same cycle
    assign ready_now = link_established_i & can_serve_i
                     & ~fatal_error_i & ~lif.err_held;            // [R5] [R6]

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.sync1 = {volt_le11_i, volt_le18_i, supply_short_i, line_short_i,
                        port_aux_input_i, line_level_i};
        st_nxt.sync2 = st_r.sync1;
        if (cyc_refresh_i)                                        // [R14]
        begin
            st_nxt.image[0] = `PMSII_RST_WORD;
            st_nxt.image[0][`PMSII_BIT_WARN]  = minor_error_i;    // [R2] [R3]
            st_nxt.image[0][`PMSII_BIT_ERR]   = lif.err_held | fatal_error_i; // [R4]
            st_nxt.image[0][`PMSII_BIT_READY] = ready_now;        // [R5] [R6]
            for (int n = 0; n < `PMSII_NPORTS; n++)
            begin
                st_nxt.image[1][2*n]   = s.line_level[n] & standard_io_mode_i[n]; // [R7] [R8]
                st_nxt.image[1][2*n+1] = s.port_aux_input[n] & mode_configured_i[n]; // [R7] [R8]
                st_nxt.image[2][2*n]   = s.line_short[n];     // [R9]
                st_nxt.image[2][2*n+1] = 1'b0;                // [R9]
            end
            st_nxt.image[3] = `PMSII_RST_WORD;
            st_nxt.image[3][7:0] = lif.supply_held | s.supply_short; // [R10]
            st_nxt.image[3][`PMSII_BIT_LE18] = s.volt_le18;       // [R11]
            st_nxt.image[3][`PMSII_BIT_LE11] = s.volt_le11;       // [R11]
            st_nxt.image[4] = {lif.evt_flags, link_mode_running_i}; // [R12] [R13]
            st_nxt.image[5] = {8'h00, pd_valid_i};                // [R13]
            st_nxt.image[6] = {8'h00, valid_error_i};             // [R13]
        end
        st_nxt.rd_valid = rd_en_i;
        if (rd_en_i)
        begin
            st_nxt.rd_data = read_word(st_r.image, rd_addr_i);
        end
        // Writes reach no storage; they are only acknowledged as refused
        st_nxt.wr_ignored = wr_en_i;                              // [R1]
    end

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign rd_data_o    = st_r.rd_data;
    assign rd_valid_o   = st_r.rd_valid;
    assign wr_ignored_o = st_r.wr_ignored;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);

    property p_ro;
        (wr_en_i && !cyc_refresh_i) |=> $stable(st_r.image) && wr_ignored_o;
    endproperty
    a_ro: assert property (p_ro) // [R1]
        else $error("write changed the image");

    property p_warn;
        (cyc_refresh_i && minor_error_i && ready_now)
            |=> st_r.image[0][`PMSII_BIT_WARN] && st_r.image[0][`PMSII_BIT_READY];
    endproperty
    a_warn: assert property (p_warn) // [R2]
        else $error("warning without ready");

    property p_warn_clr;
        (cyc_refresh_i && !minor_error_i) |=> !st_r.image[0][`PMSII_BIT_WARN];
    endproperty
    a_warn_clr: assert property (p_warn_clr) // [R3]
        else $error("warning not self cleared");

    sequence s_fatal_seen;
        fatal_error_i ##1 cyc_refresh_i;
    endsequence
    property p_err_bit;
        s_fatal_seen |=> st_r.image[0][`PMSII_BIT_ERR] && !st_r.image[0][`PMSII_BIT_READY];
    endproperty
    a_err_bit: assert property (p_err_bit) // [R4]
        else $error("error bit or ready wrong after fatal");

    property p_ready_on;
        (cyc_refresh_i && link_established_i && can_serve_i && !fatal_error_i
            && !lif.err_held) |=> st_r.image[0][`PMSII_BIT_READY];
    endproperty
    a_ready_on: assert property (p_ready_on) // [R5]
        else $error("ready missing with link up");

    property p_ready_off;
        (cyc_refresh_i && !can_serve_i) |=> !st_r.image[0][`PMSII_BIT_READY];
    endproperty
    a_ready_off: assert property (p_ready_off) // [R6]
        else $error("ready on while unable to serve");

    property p_ext;
        cyc_refresh_i |=> st_r.image[1][0] == $past(s.line_level[0] && standard_io_mode_i[0])
                      && st_r.image[1][1] == $past(s.port_aux_input[0] && mode_configured_i[0]);
    endproperty
    a_ext: assert property (p_ext) // [R7]
        else $error("port 1 input bits wrong");

    property p_sig_valid;
        (cyc_refresh_i && !standard_io_mode_i[5]) |=> !st_r.image[1][10];
    endproperty
    a_sig_valid: assert property (p_sig_valid) // [R8]
        else $error("signal bit shown outside input mode");

    property p_short_odd;
        cyc_refresh_i |=> (st_r.image[2] & `PMSII_ODD_MASK) == `PMSII_RST_WORD;
    endproperty
    a_short_odd: assert property (p_short_odd) // [R9]
        else $error("odd short bit set");

    property p_volt;
        cyc_refresh_i |=> st_r.image[3][`PMSII_BIT_LE18] == $past(s.volt_le18)
                      && st_r.image[3][`PMSII_BIT_LE11] == $past(s.volt_le11);
    endproperty
    a_volt: assert property (p_volt) // [R11]
        else $error("low supply bits wrong");

    property p_flags;
        cyc_refresh_i |=> st_r.image[5][7:0] == $past(pd_valid_i)
                      && st_r.image[6][15:8] == 8'h00;
    endproperty
    a_flags: assert property (p_flags) // [R13]
        else $error("per-port flag word wrong");

    property p_read;
        (rd_en_i && rd_addr_i == `PMSII_OFS_SYS && !cyc_refresh_i)
            |=> rd_valid_o && rd_data_o == st_r.image[0];
    endproperty
    a_read: assert property (p_read) // [R14]
        else $error("read answer wrong");
endmodule // pmsii_status_image
`default_nettype wire

// ==== pmsii_params.svh ====
// Offsets, bit positions and reset values of the port status input bit image
`ifndef PMSII_PARAMS_SVH
`define PMSII_PARAMS_SVH
`define PMSII_NPORTS    8
`define PMSII_NWORDS    7
`define PMSII_OFS_SYS   7'h00
`define PMSII_OFS_EXT   7'h10
`define PMSII_OFS_SHORT 7'h20
`define PMSII_OFS_SUPP  7'h30
`define PMSII_OFS_MODE  7'h40
`define PMSII_OFS_PDV   7'h50
`define PMSII_OFS_VERR  7'h60
`define PMSII_BIT_WARN  7
`define PMSII_BIT_ERR   10
`define PMSII_BIT_READY 11
`define PMSII_BIT_LE18  8
`define PMSII_BIT_LE11  9
`define PMSII_EVT_LSB   8
`define PMSII_ODD_MASK  16'haaaa
`define PMSII_RST_WORD  16'h0000
`endif

// ==== pmsii_pkg.sv ====
// Types shared by the port status input bit image modules
`include "pmsii_params.svh"
package pmsii_pkg;
    typedef logic [15:0] pmsii_word_t;
    typedef logic [`PMSII_NWORDS-1:0][15:0] pmsii_image_t;
    typedef struct packed {
        logic       volt_le11;
        logic       volt_le18;
        logic [7:0] supply_short;
        logic [7:0] line_short;
        logic [7:0] port_aux_input;
        logic [7:0] line_level;
    } pmsii_pins_t;
    typedef struct packed {
        pmsii_pins_t  sync1;
        pmsii_pins_t  sync2;
        pmsii_image_t image;
        pmsii_word_t  rd_data;
        logic         rd_valid;
        logic         wr_ignored;
    } pmsii_main_t;
    typedef struct packed {
        logic       err;
        logic [7:0] supply;
        logic [7:0] evt;
    } pmsii_latch_t;
endpackage

// ==== pmsii_latch_if.sv ====
// Carrier between the image builder and its latched flag unit
`timescale 1ns/1ps
`default_nettype none
interface pmsii_latch_if;
    logic       fatal;
    logic [7:0] supply_short;
    logic [7:0] evt_report;
    logic [7:0] evt_clear;
    logic [7:0] evt_read;
    logic       err_held;
    logic [7:0] supply_held;
    logic [7:0] evt_flags;
    modport ctrl (output fatal, supply_short, evt_report, evt_clear, evt_read,
                  input err_held, supply_held, evt_flags);
    modport unit (input fatal, supply_short, evt_report, evt_clear, evt_read,
                  output err_held, supply_held, evt_flags);
endinterface
`default_nettype wire

// ==== pmsii_latch_unit.sv ====
// Sticky flags: error latch, supply short latches, per-port event flags
`timescale 1ns/1ps
`default_nettype none
module pmsii_latch_unit (
    input  wire logic        clock_i,  // Device clock
    input  wire logic        rst_b_i,  // Power-up reset, active low
    pmsii_latch_if.unit      lif       // Flag requests and held flags
);
    import pmsii_pkg::*;

    pmsii_latch_t st_r;
    pmsii_latch_t st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        // Only a power cycle clears the error and supply latches
        if (lif.fatal)
        begin
            st_nxt.err = 1'b1;                                    // [R4]
        end
        st_nxt.supply = st_r.supply | lif.supply_short;           // [R10]
        // Set wins over clear so an event in the clearing cycle survives
        st_nxt.evt = (st_r.evt & ~(lif.evt_clear | lif.evt_read))
                   | lif.evt_report;                              // [R12]
    end

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign lif.err_held    = st_r.err;
    assign lif.supply_held = st_r.supply;
    assign lif.evt_flags   = st_r.evt;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_err_set;
        lif.fatal;
    endsequence
    sequence s_err_held;
        lif.err_held [*8];
    endsequence
    property p_err_latch;
        s_err_set |=> s_err_held;
    endproperty
    a_err_latch: assert property (p_err_latch) // [R4]
        else $error("error flag not held after fatal error");

    property p_supply_latch;
        (lif.supply_short[2] || lif.supply_held[2]) |=> lif.supply_held[2];
    endproperty
    a_supply_latch: assert property (p_supply_latch) // [R10]
        else $error("supply short flag not latched");

    property p_evt_set;
        lif.evt_report[2] |=> lif.evt_flags[2];
    endproperty
    a_evt_set: assert property (p_evt_set) // [R12]
        else $error("event flag not set by report");

    property p_evt_clear;
        (lif.evt_clear[2] && !lif.evt_report[2]) |=> !lif.evt_flags[2];
    endproperty
    a_evt_clear: assert property (p_evt_clear) // [R12]
        else $error("event flag not cleared");
endmodule // pmsii_latch_unit
`default_nettype wire

// ==== pmsii_master_model.sv ====
// Behavioural fieldbus master station: cyclic refresh, word reads and write attempts
`timescale 1ns/1ps
`default_nettype none
module pmsii_master_model (
    input  wire logic                   clock_i,        // Device clock
    input  wire pmsii_pkg::pmsii_word_t rd_data_i,      // Read word from the image
    input  wire logic                   rd_valid_i,     // Read answer strobe
    output logic                        cyc_refresh_o,  // Cyclic exchange strobe
    output logic                        rd_en_o,        // Read strobe
    output logic [6:0]                  rd_addr_o,      // Word bit address
    output logic                        wr_en_o,        // Write attempt
    output logic [6:0]                  wr_addr_o,      // Write bit address
    output logic [15:0]                 wr_data_o       // Write data
);
    import pmsii_pkg::*;
    initial
    begin
        cyc_refresh_o = 1'b0;
        rd_en_o       = 1'b0;
        rd_addr_o     = 7'h00;
        wr_en_o       = 1'b0;
        wr_addr_o     = 7'h00;
        wr_data_o     = 16'h0000;
    end
    task automatic refresh();
        @(posedge clock_i);
        cyc_refresh_o <= 1'b1;
        @(posedge clock_i);
        cyc_refresh_o <= 1'b0;
    endtask
    // Released lines carry the inverse so a stale address can never look valid
    task automatic read_word(input logic [6:0] addr, output pmsii_word_t data, output logic ok);
        @(posedge clock_i);
        rd_en_o   <= 1'b1;
        rd_addr_o <= addr;
        @(posedge clock_i);
        rd_en_o   <= 1'b0;
        rd_addr_o <= ~addr;
        #1;
        // Answer latency is exactly one cycle, so no longer wait is granted
        ok   = (rd_valid_i === 1'b1);
        data = rd_data_i;
    endtask
    task automatic write_word(input logic [6:0] addr, input logic [15:0] data);
        @(posedge clock_i);
        wr_en_o   <= 1'b1;
        wr_addr_o <= addr;
        wr_data_o <= data;
        @(posedge clock_i);
        wr_en_o   <= 1'b0;
        wr_addr_o <= ~addr;
        wr_data_o <= ~data;
        #1;
    endtask
endmodule // pmsii_master_model
`default_nettype wire

// ==== pmsii_status_image_test.sv ====
// Self-checking bench for the port status input bit image
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin n_tests++; if ((got) !== (exp)) begin fail_count++; \
    $display("mismatch %s expected %h seen %h", what, exp, got); end end
module pmsii_status_image_test;
    import pmsii_pkg::*;
    logic        clock_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic [7:0]  line_level, aux_in, line_short, supply_short, mode_cfg, stdio;
    logic [7:0]  running, pd_valid, verr, evt_report, evt_clear, evt_read;
    logic        le18, le11, minor_err, fatal_err, link_up, can_serve;
    logic        cyc_refresh, rd_en, wr_en, rd_valid, wr_ignored;
    logic [6:0]  rd_addr, wr_addr;
    logic [15:0] wr_data;
    pmsii_word_t rd_data;
    int          fail_count = 0;
    int          n_tests = 0;
    initial
    begin
        {line_level, aux_in, line_short, supply_short, mode_cfg, stdio} = '0;
        {running, pd_valid, verr, evt_report, evt_clear, evt_read} = '0;
        {le18, le11, minor_err, fatal_err, link_up, can_serve} = '0;
    end
    always #50 clock_i = ~clock_i;
    pmsii_status_image pmsii_status_image_i (
        .clock_i(clock_i), .rst_b_i(rst_b_i), .line_level_i(line_level),
        .port_aux_input_i(aux_in), .line_short_i(line_short), .supply_short_i(supply_short),
        .volt_le18_i(le18), .volt_le11_i(le11), .minor_error_i(minor_err),
        .fatal_error_i(fatal_err), .link_established_i(link_up), .can_serve_i(can_serve),
        .mode_configured_i(mode_cfg), .standard_io_mode_i(stdio),
        .link_mode_running_i(running), .pd_valid_i(pd_valid), .valid_error_i(verr),
        .evt_report_i(evt_report), .evt_clear_req_i(evt_clear), .evt_read_i(evt_read),
        .cyc_refresh_i(cyc_refresh), .rd_en_i(rd_en), .rd_addr_i(rd_addr),
        .rd_data_o(rd_data), .rd_valid_o(rd_valid), .wr_en_i(wr_en), .wr_addr_i(wr_addr),
        .wr_data_i(wr_data), .wr_ignored_o(wr_ignored)
    );
    pmsii_master_model pmsii_master_model_i (
        .clock_i(clock_i), .rd_data_i(rd_data), .rd_valid_i(rd_valid),
        .cyc_refresh_o(cyc_refresh), .rd_en_o(rd_en), .rd_addr_o(rd_addr),
        .wr_en_o(wr_en), .wr_addr_o(wr_addr), .wr_data_o(wr_data)
    );
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Pins pass a two-stage synchroniser, so let them settle before the snapshot
    task automatic settle_refresh();
        repeat (3) @(posedge clock_i);
        pmsii_master_model_i.refresh();
    endtask
    task automatic check_word(input logic [6:0] addr, input logic [15:0] exp, input string what);
        pmsii_word_t d;
        logic        ok;
        pmsii_master_model_i.read_word(addr, d, ok);
        `CHK(what, exp, d)
        `CHK("read answer strobe", 1'b1, ok)
        if (ok !== 1'b1)
        begin
            complete_run();
        end
    endtask
    task automatic evt_pulse(input int kind, input logic [7:0] v);
        @(posedge clock_i);
        if (kind == 0)
            evt_report <= v;
        else if (kind == 1)
            evt_clear <= v;
        else
            evt_read <= v;
        @(posedge clock_i);
        evt_report <= 8'h00;
        evt_clear  <= 8'h00;
        evt_read   <= 8'h00;
    endtask
    function automatic logic [15:0] ext_exp(logic [7:0] lv, logic [7:0] ax, logic [7:0] iom,
                                            logic [7:0] cfg);
        logic [15:0] e;
        for (int n = 0; n < 8; n++)
        begin
            e[2*n]   = lv[n] & iom[n];
            e[2*n+1] = ax[n] & cfg[n];
        end
        return e;
    endfunction
    task automatic ext_case(input logic [7:0] lv, ax, iom, cfg);
        @(posedge clock_i);
        line_level <= lv;
        aux_in     <= ax;
        stdio      <= iom;
        mode_cfg   <= cfg;
        settle_refresh();
        check_word(7'h10, ext_exp(lv, ax, iom, cfg), "external inputs");
    endtask
    initial
    begin
        repeat (50000) @(posedge clock_i);
        fail_count++;
        complete_run();
    end
    initial
    begin
        repeat (10) @(posedge clock_i);
        rst_b_i <= 1'b1;
        check_word(7'h00, 16'h0000, "system word after reset");
        @(posedge clock_i);
        {link_up, can_serve, minor_err} <= 3'b111;
        settle_refresh();
        check_word(7'h00, 16'h0880, "warning with ready");
        @(posedge clock_i);
        minor_err <= 1'b0;
        settle_refresh();
        check_word(7'h00, 16'h0800, "warning self clear");
        @(posedge clock_i);
        can_serve <= 1'b0;
        settle_refresh();
        check_word(7'h00, 16'h0000, "ready without service");
        @(posedge clock_i);
        {link_up, can_serve} <= 2'b01;
        settle_refresh();
        check_word(7'h00, 16'h0000, "ready without link");
        @(posedge clock_i);
        link_up <= 1'b1;
        ext_case(8'ha5, 8'h3c, 8'hf0, 8'h0f);
        ext_case(8'hff, 8'hff, 8'h55, 8'haa);
        @(posedge clock_i);
        line_short   <= 8'h81;
        supply_short <= 8'h04;
        le18         <= 1'b1;
        settle_refresh();
        check_word(7'h20, 16'h4001, "line short");
        check_word(7'h30, 16'h0104, "supply low 18");
        @(posedge clock_i);
        {supply_short, le18, le11} <= {8'h00, 1'b0, 1'b1};
        settle_refresh();
        check_word(7'h30, 16'h0204, "supply held low 11");
        @(posedge clock_i);
        running <= 8'h5a;
        evt_pulse(0, 8'h04);
        settle_refresh();
        check_word(7'h40, 16'h045a, "event set");
        evt_pulse(1, 8'h04);
        evt_pulse(0, 8'h80);
        settle_refresh();
        check_word(7'h40, 16'h805a, "event clear request");
        evt_pulse(2, 8'h80);
        settle_refresh();
        check_word(7'h40, 16'h005a, "event read");
        @(posedge clock_i);
        pd_valid <= 8'hc3;
        verr     <= 8'h3c;
        settle_refresh();
        check_word(7'h50, 16'h00c3, "data valid");
        check_word(7'h60, 16'h003c, "validation error");
        @(posedge clock_i);
        pd_valid <= 8'h0f;
        repeat (3) @(posedge clock_i);
        check_word(7'h50, 16'h00c3, "snapshot held");
        pmsii_master_model_i.refresh();
        check_word(7'h50, 16'h000f, "snapshot refreshed");
        pmsii_master_model_i.write_word(7'h00, 16'hffff);
        `CHK("write refused", 1'b1, wr_ignored)
        check_word(7'h00, 16'h0800, "system word after write");
        check_word(7'h05, 16'h0000, "unaligned read");
        check_word(7'h70, 16'h0000, "unmapped read");
        @(posedge clock_i);
        fatal_err <= 1'b1;
        settle_refresh();
        check_word(7'h00, 16'h0400, "fatal error");
        @(posedge clock_i);
        fatal_err <= 1'b0;
        settle_refresh();
        check_word(7'h00, 16'h0400, "error held");
        complete_run();
    end
endmodule // pmsii_status_image_test
`default_nettype wire
